// ### core/tft_timing_pkg.sv
// Constants shared by the panel timing register block and its helpers
package tft_timing_pkg;

	// Bus and counter widths
	localparam int ADDR_W   = 8;
	localparam int DATA_W   = 8;
	localparam int CNT_W    = 11;
	localparam int NUM_REGS = 8;
	localparam int IDX_W    = 3;

	// Register offsets, contiguous from the first to the last
	localparam logic [7:0] OFF_VACT_LO = 8'h3D;
	localparam logic [7:0] OFF_VACT_HI = 8'h3E;
	localparam logic [7:0] OFF_VST_LO  = 8'h3F;
	localparam logic [7:0] OFF_VST_HI  = 8'h40;
	localparam logic [7:0] OFF_FSW     = 8'h41;
	localparam logic [7:0] OFF_LSW     = 8'h42;
	localparam logic [7:0] OFF_LSP_LO  = 8'h43;
	localparam logic [7:0] OFF_LSP_HI  = 8'h44;

	// Index of each register inside the storage array
	localparam int IDX_VACT_LO = 0;
	localparam int IDX_VACT_HI = 1;
	localparam int IDX_VST_LO  = 2;
	localparam int IDX_VST_HI  = 3;
	localparam int IDX_FSW     = 4;
	localparam int IDX_LSW     = 5;
	localparam int IDX_LSP_LO  = 6;
	localparam int IDX_LSP_HI  = 7;

	// High parts keep bits 2-0; bit 3 reserved, upper bits absent
	localparam int         HI_FIELD_MSB = 2;
	localparam logic [7:0] MASK_FULL    = 8'hFF;
	localparam logic [7:0] MASK_HI      = 8'h07;

	// Reset values
	localparam logic [7:0] RST_FSW   = 8'h02;
	localparam logic [7:0] RST_LSW   = 8'h07;
	localparam logic [7:0] RST_OTHER = 8'h00;

	// Per register reset value, in index order
	localparam logic [7:0] REG_RESET [NUM_REGS] = '{
		RST_OTHER, RST_OTHER, RST_OTHER, RST_OTHER,
		RST_FSW,   RST_LSW,   RST_OTHER, RST_OTHER
	};

	// Per register writable bits, in index order
	localparam logic [7:0] REG_WMASK [NUM_REGS] = '{
		MASK_FULL, MASK_HI, MASK_FULL, MASK_HI,
		MASK_FULL, MASK_FULL, MASK_FULL, MASK_HI
	};

	// Frame sync always starts on the first line of the frame
	localparam logic [10:0] FRAME_SYNC_START = 11'h000;

	// Read data for an unmapped address
	localparam logic [7:0] RD_UNMAPPED = 8'h00;

endpackage

// ### core/sync_window.sv
// Window decoder: high while a count lies in a start-plus-length span
`timescale 1ns/10ps
`default_nettype none

module sync_window
	import tft_timing_pkg::*;
(
	input  wire logic [CNT_W-1:0] i_count,   // Running pixel or line count
	input  wire logic [CNT_W-1:0] i_start,   // First count inside window
	input  wire logic [CNT_W-1:0] i_len_m1,  // Window length minus one
	output logic                  o_inside   // Count is inside window
);
	// Distance from the window start, only meaningful past the start
	wire [CNT_W-1:0] offset = i_count - i_start;

	// Past the start
	wire past_start = (i_count >= i_start);

	// Within length; a window reaching beyond the count range is cut there
	wire within_len = (offset <= i_len_m1);

	// Combinational decision; the caller registers it
	assign o_inside = past_start && within_len;

endmodule
`default_nettype wire

// ### core/tft_frame_line_timing_regs.sv
// Panel timing registers with the pixel/line counter and sync generator
//
// What this block does
// - Holds 11-bit start line of active lines
// - Start line joins high bits 2-0, low byte
// - Frame sync lasts register plus one lines
// - Line sync lasts register plus one pixels
// - Line sync starts at programmed pixel position
// - Line sync position joins low, next register
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module tft_frame_line_timing_regs
	import tft_timing_pkg::*;
(
	input  wire logic                         i_clk,            // System clock
	input  wire logic                         i_sys_rst,        // Sync reset, high
	input  wire logic [tft_timing_pkg::ADDR_W-1:0] i_addr,      // Register address
	input  wire logic [tft_timing_pkg::DATA_W-1:0] i_wr_data,   // Write data
	input  wire logic                         i_wr_strobe,      // Write strobe
	input  wire logic                         i_rd_strobe,      // Read strobe
	output logic      [tft_timing_pkg::DATA_W-1:0] o_rd_data,   // Read data, next cycle
	input  wire logic [tft_timing_pkg::CNT_W-1:0]  i_line_total,  // Last pixel index
	input  wire logic [tft_timing_pkg::CNT_W-1:0]  i_frame_total, // Last line index
	output logic                              o_line_sync_out,  // Line sync pulse
	output logic                              o_frame_sync_out, // Frame sync pulse
	output logic                              o_vert_active,    // Active line period
	output logic      [tft_timing_pkg::CNT_W-1:0]  o_pixel_count, // Pixel count
	output logic      [tft_timing_pkg::CNT_W-1:0]  o_line_count   // Line count
);
	import tft_timing_pkg::*;

	// Address falls inside the register window
	function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
		reg_hit = (a >= OFF_VACT_LO) && (a <= OFF_LSP_HI);
	endfunction

	// Storage index of an address inside the window
	function automatic logic [IDX_W-1:0] reg_idx(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] d;
		d       = a - OFF_VACT_LO;
		reg_idx = d[IDX_W-1:0];
	endfunction

	// Register storage, one byte per offset
	logic [DATA_W-1:0] regs_q [NUM_REGS];

	// Read data register
	logic [DATA_W-1:0] rd_data_q;
	logic [DATA_W-1:0] rd_data_d;

	// Timing counters
	logic [CNT_W-1:0] pix_q;
	logic [CNT_W-1:0] pix_d;
	logic [CNT_W-1:0] line_q;
	logic [CNT_W-1:0] line_d;

	// Registered sync outputs
	logic             line_sync_q;
	logic             frame_sync_q;
	logic             vert_active_q;
	logic [CNT_W-1:0] pix_out_q;
	logic [CNT_W-1:0] line_out_q;

	// Bus decode, shared by write and read paths
	wire              addr_hit = reg_hit(i_addr);
	wire [IDX_W-1:0]  addr_idx = reg_idx(i_addr);
	wire              wr_hit   = i_wr_strobe && addr_hit;

	// Writes into each register; masked bits stay zero
	genvar gi;
	generate
		for (gi = 0; gi < NUM_REGS; gi++)
		begin : g_reg
			// Only the field bits of high parts take writes,
			// so a stray write to reserved bit 3 cannot upset the timing
			always_ff @(posedge i_clk)
			begin
				if (i_sys_rst)
					regs_q[gi] <= REG_RESET[gi];
				else if (wr_hit && (addr_idx == IDX_W'(gi)))
					regs_q[gi] <= i_wr_data & REG_WMASK[gi];
			end
		end
	endgenerate

	wire [CNT_W-1:0] vert_start_line =
		{regs_q[IDX_VST_HI][HI_FIELD_MSB:0], regs_q[IDX_VST_LO]};

	wire [CNT_W-1:0] vert_active_lines =
		{regs_q[IDX_VACT_HI][HI_FIELD_MSB:0], regs_q[IDX_VACT_LO]};

	wire [CNT_W-1:0] line_sync_position =
		{regs_q[IDX_LSP_HI][HI_FIELD_MSB:0], regs_q[IDX_LSP_LO]};

	// Widths are already length minus one
	wire [CNT_W-1:0] frame_sync_width = {3'h0, regs_q[IDX_FSW]};
	wire [CNT_W-1:0] line_sync_width  = {3'h0, regs_q[IDX_LSW]};

	// Read mux; reserved and absent bits read as zero from storage
	assign rd_data_d = addr_hit ? regs_q[addr_idx] : RD_UNMAPPED;

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			rd_data_q <= RD_UNMAPPED;
		else if (i_rd_strobe)
			rd_data_q <= rd_data_d;
		else
			rd_data_q <= RD_UNMAPPED;
	end

	// Counter wrap points come from the outside totals
	wire pix_wrap  = (pix_q == i_line_total);
	wire line_wrap = (line_q == i_frame_total);

	// Next counts; a total lowered below the count wraps only at 2047
	assign pix_d  = pix_wrap ? '0 : pix_q + 11'h001;
	assign line_d = !pix_wrap ? line_q :
		(line_wrap ? '0 : line_q + 11'h001);

	// Pixel and line counters
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			pix_q  <= '0;
			line_q <= '0;
		end
		else
		begin
			pix_q  <= pix_d;
			line_q <= line_d;
		end
	end

	// Window decisions, combinational
	logic ls_inside;
	logic fs_inside;
	logic va_inside;

	sync_window u_line_sync (
		.i_count  (pix_q),
		.i_start  (line_sync_position),
		.i_len_m1 (line_sync_width),
		.o_inside (ls_inside)
	);

	sync_window u_frame_sync (
		.i_count  (line_q),
		.i_start  (FRAME_SYNC_START),
		.i_len_m1 (frame_sync_width),
		.o_inside (fs_inside)
	);

	sync_window u_vert_active (
		.i_count  (line_q),
		.i_start  (vert_start_line),
		.i_len_m1 (vert_active_lines),
		.o_inside (va_inside)
	);

	// Outputs registered with the counts they belong to,
	// so the panel sees sync and counts aligned to the same edge
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			line_sync_q   <= 1'b0;
			frame_sync_q  <= 1'b0;
			vert_active_q <= 1'b0;
			pix_out_q     <= '0;
			line_out_q    <= '0;
		end
		else
		begin
			line_sync_q   <= ls_inside;
			frame_sync_q  <= fs_inside;
			vert_active_q <= va_inside;
			pix_out_q     <= pix_q;
			line_out_q    <= line_q;
		end
	end

	// Port drives
	assign o_rd_data        = rd_data_q;
	assign o_line_sync_out  = line_sync_q;
	assign o_frame_sync_out = frame_sync_q;
	assign o_vert_active    = vert_active_q;
	assign o_pixel_count    = pix_out_q;
	assign o_line_count     = line_out_q;

	// Expected end counts, one bit wider so they cannot wrap
	wire [CNT_W:0] ls_end = {1'b0, line_sync_position}
		+ {1'b0, line_sync_width} + 12'h001;
	wire [CNT_W:0] fs_end = {1'b0, frame_sync_width} + 12'h001;
	wire [CNT_W:0] va_end = {1'b0, vert_start_line}
		+ {1'b0, vert_active_lines} + 12'h001;

	// All checks share one clock and the reset
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);

	// Timing checks skip the second cycle after a register write:
	// software may move a window under a running count, and the
	// pulse then starts or stops where the new window takes over
	// rather than at its programmed edge. That is legal behaviour,
	// so it must not be flagged as a timing fault.

	a_vact_start_line: assert property (
		!$past(wr_hit, 2) && $rose(o_vert_active)
		|-> o_line_count == $past(vert_start_line))
		else $error("active period began on wrong line");

	a_vact_end_line: assert property (
		!$past(wr_hit, 2)
			&& $fell(o_vert_active) && o_line_count != '0
		|-> {1'b0, o_line_count} == $past(va_end))
		else $error("active period length wrong");

	a_vstart_assembly: assert property (
		i_wr_strobe && i_addr == OFF_VST_HI
		|=> vert_start_line[CNT_W-1:DATA_W] == $past(i_wr_data[HI_FIELD_MSB:0])
			&& regs_q[IDX_VST_HI][DATA_W-1:HI_FIELD_MSB+1] == '0)
		else $error("start line high part not assembled");

	a_fsync_start: assert property (
		!$past(wr_hit, 2) && $rose(o_frame_sync_out)
		|-> o_line_count == FRAME_SYNC_START)
		else $error("frame sync began off first line");

	a_fsync_width: assert property (
		!$past(wr_hit, 2)
			&& $fell(o_frame_sync_out) && o_line_count != '0
		|-> {1'b0, o_line_count} == $past(fs_end))
		else $error("frame sync length wrong");

	a_lsync_start: assert property (
		!$past(wr_hit, 2) && $rose(o_line_sync_out)
		|-> o_pixel_count == $past(line_sync_position))
		else $error("line sync began at wrong pixel");

	a_lsync_width: assert property (
		!$past(wr_hit, 2)
			&& $fell(o_line_sync_out) && o_pixel_count != '0
		|-> {1'b0, o_pixel_count} == $past(ls_end))
		else $error("line sync length wrong");

	a_lsp_readback: assert property (
		i_rd_strobe && i_addr == OFF_LSP_HI
		|=> o_rd_data == {5'h00, $past(line_sync_position[CNT_W-1:DATA_W])}
		##1 o_rd_data == RD_UNMAPPED || $past(i_rd_strobe))
		else $error("position high part read wrong");

	a_width_reset: assert property (
		$past(i_sys_rst) |-> regs_q[IDX_FSW] == RST_FSW
			&& regs_q[IDX_LSW] == RST_LSW)
		else $error("sync widths not at reset values");

	a_fsw_write: assert property (
		i_wr_strobe && i_addr == OFF_FSW
		|=> frame_sync_width == {3'h0, $past(i_wr_data)})
		else $error("frame sync width write lost");

	a_lsw_write: assert property (
		i_wr_strobe && i_addr == OFF_LSW
		|=> line_sync_width == {3'h0, $past(i_wr_data)})
		else $error("line sync width write lost");

	a_lsp_low_write: assert property (
		i_wr_strobe && i_addr == OFF_LSP_LO
		|=> line_sync_position[DATA_W-1:0] == $past(i_wr_data))
		else $error("line sync position low byte lost");

	a_vact_assembly: assert property (
		i_wr_strobe && i_addr == OFF_VACT_HI
		|=> vert_active_lines[CNT_W-1:DATA_W] == $past(i_wr_data[HI_FIELD_MSB:0]))
		else $error("active lines high part not assembled");

	// Main scenarios
	c_frame_sync: cover property ($rose(o_frame_sync_out));
	c_line_sync:  cover property ($fell(o_line_sync_out));
	c_vert_end:   cover property ($fell(o_vert_active));
	c_read_back:  cover property (i_wr_strobe ##1 i_rd_strobe);

endmodule
`default_nettype wire

// ### tb/sync_pulse_meter.sv
// Panel side model: measures where one sync pulse starts and how long it lasts
`timescale 1ns/10ps
`default_nettype none

module sync_pulse_meter
	import tft_timing_pkg::*;
(
	input  wire logic             i_clk,   // System clock
	input  wire logic             i_level, // Sync level seen by panel
	input  wire logic [CNT_W-1:0] i_count, // Count aligned with the sync
	output logic      [CNT_W-1:0] o_start, // Count at last pulse start
	output logic      [15:0]      o_len    // Cycles of last whole pulse
);
	logic             prev_q;  // Level one cycle ago
	logic [15:0]      run_q;   // Cycles of the pulse in progress
	logic [CNT_W-1:0] first_q; // Start count of the pulse in progress

	// Results latch only on the falling edge, so a half pulse never shows
	always_ff @(posedge i_clk)
	begin
		prev_q <= i_level;
		if (i_level && !prev_q)
		begin
			first_q <= i_count;
			run_q   <= 16'h0001;
		end
		else if (i_level)
			run_q <= run_q + 16'h0001;
		if (!i_level && prev_q)
		begin
			o_start <= first_q;
			o_len   <= run_q;
		end
	end
endmodule
`default_nettype wire

// ### tb/test_tft_frame_line_timing_regs.sv
// Self-checking bench for the panel timing register block
`timescale 1ns/10ps
`default_nettype none

module test_tft_frame_line_timing_regs;
	import tft_timing_pkg::*;
	logic             i_clk = 1'b0;       // Clock
	logic             i_sys_rst = 1'b1;   // Reset
	logic [7:0]       i_addr = 8'h00;     // Bus address
	logic [7:0]       i_wr_data = 8'h00;  // Bus write data
	logic             i_wr_strobe = 1'b0; // Write strobe
	logic             i_rd_strobe = 1'b0; // Read strobe
	logic [7:0]       o_rd_data;          // Read data
	logic [10:0]      i_line_total = 11'h10F;  // Last pixel index
	logic [10:0]      i_frame_total = 11'h10F; // Last line index
	logic             ls, fs, va;         // Sync outputs
	logic [10:0]      pix, lin;           // Counts
	logic [10:0]      ls_st, fs_st, va_st; // Measured starts
	logic [15:0]      ls_ln, fs_ln, va_ln; // Measured lengths
	int               n_mismatch = 0;     // Mismatch count
	int               n_checks = 0;       // Comparison count

	always #2 i_clk = ~i_clk;

	tft_frame_line_timing_regs DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
		.i_wr_data(i_wr_data), .i_wr_strobe(i_wr_strobe), .i_rd_strobe(i_rd_strobe),
		.o_rd_data(o_rd_data), .i_line_total(i_line_total), .i_frame_total(i_frame_total),
		.o_line_sync_out(ls), .o_frame_sync_out(fs), .o_vert_active(va),
		.o_pixel_count(pix), .o_line_count(lin));
	sync_pulse_meter m_ls (.i_clk(i_clk), .i_level(ls), .i_count(pix), .o_start(ls_st), .o_len(ls_ln));
	sync_pulse_meter m_fs (.i_clk(i_clk), .i_level(fs), .i_count(lin), .o_start(fs_st), .o_len(fs_ln));
	sync_pulse_meter m_va (.i_clk(i_clk), .i_level(va), .i_count(lin), .o_start(va_st), .o_len(va_ln));

	// Compare one value and count it
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a; i_wr_data <= d; i_wr_strobe <= 1'b1;
		@(posedge i_clk);
		i_wr_strobe <= 1'b0;
	endtask

	// One-cycle read; data is looked at in the following cycle only
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_clk);
		i_addr <= a; i_rd_strobe <= 1'b1;
		@(posedge i_clk);
		i_rd_strobe <= 1'b0;
		#1 chk("read data", {8'h00, exp}, {8'h00, o_rd_data});
	endtask

	// Reset values of every register
	task automatic t_reset_vals();
		for (int i = 0; i < 8; i++)
			rd(OFF_VACT_LO + 8'(i), (i == 4) ? 8'h02 : (i == 5) ? 8'h07 : 8'h00);
		@(posedge i_clk);
		#1 chk("idle read data", 16'h0000, {8'h00, o_rd_data});
	endtask

	// High parts keep three bits; unmapped places hold nothing
	task automatic t_reg_mask();
		for (int i = 0; i < 8; i++)
		begin
			wr(OFF_VACT_LO + 8'(i), 8'hFF);
			rd(OFF_VACT_LO + 8'(i), (i == 1 || i == 3 || i == 7) ? 8'h07 : 8'hFF);
		end
		wr(8'h3C, 8'h5A);
		rd(8'h3C, 8'h00);
		wr(8'h45, 8'h5A);
		rd(8'h45, 8'h00);
	endtask

	// Line sync at a position that needs the high part, width four pixels
	task automatic t_line_sync();
		wr(OFF_LSP_LO, 8'h03);
		wr(OFF_LSP_HI, 8'h01);
		wr(OFF_LSW, 8'h03);
		repeat (2 * 272 + 10) @(posedge i_clk);
		chk("line sync start", 16'h0103, {5'h00, ls_st});
		chk("line sync width", 16'h0004, ls_ln);
	endtask

	// Frame sync and active period in lines of sixteen pixels
	task automatic t_frame();
		i_line_total <= 11'h00F;
		wr(OFF_FSW, 8'h01);
		wr(OFF_VST_LO, 8'h02);
		wr(OFF_VST_HI, 8'h01);
		wr(OFF_VACT_LO, 8'h02);
		wr(OFF_VACT_HI, 8'h00);
		repeat (2 * 16 * 272 + 20) @(posedge i_clk);
		chk("frame sync start", 16'h0000, {5'h00, fs_st});
		chk("frame sync width", 16'h0020, fs_ln);
		chk("active start", 16'h0102, {5'h00, va_st});
		chk("active length", 16'h0030, va_ln);
	endtask

	// Write then read with no gap; read data stand one cycle only
	task automatic t_back_to_back();
		@(posedge i_clk);
		i_addr <= OFF_LSW;
		i_wr_data <= 8'h05;
		i_wr_strobe <= 1'b1;
		@(posedge i_clk);
		i_wr_strobe <= 1'b0;
		i_rd_strobe <= 1'b1;
		@(posedge i_clk);
		i_rd_strobe <= 1'b0;
		#1 chk("back to back read", 16'h0005, {8'h00, o_rd_data});
		@(posedge i_clk);
		#1 chk("read data one cycle later", 16'h0000, {8'h00, o_rd_data});
	endtask

	// Verdict and end of run
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Watchdog well beyond the expected run
	initial
	begin
		#100000;
		n_mismatch++;
		wrap_up();
	end

	// Main sequence
	initial
	begin
		repeat (6) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		t_reset_vals();
		t_reg_mask();
		t_back_to_back();
		t_line_sync();
		t_frame();
		wrap_up();
	end
endmodule
`default_nettype wire
